// ===== src/adc_seq_pkg.sv
// constants and types for the converter control sequencer
//
// Behaviour
// R01 - The host opens a conversion with chip select and convert request low; the sequence starts on the convert request rising edge.
// R02 - With auto-zero enable low an auto-zero cycle of about 26 clocks runs before sampling, and the host holds it low throughout.
// R03 - When the acquisition window closes, end-of-conversion goes low as approximation begins.
// R04 - After all bits are tested and the result latched, interrupt goes low and end-of-conversion goes high.
// R05 - Without auto-zero, for either start method, the next acquisition window opens at the end-of-conversion rising edge.
// R06 - The host counts acquisition time only after both result bytes have been read.
// R07 - A convert-request start with auto-zero enabled runs auto-zero before opening the acquisition window.
// R08 - In the auto-zero method the device times the acquisition window itself at about seven clocks.
// R09 - Acquisition must last at least 3.5 us, so with auto-zero the clock may not exceed 2 MHz.
// R10 - The host may switch the clock between 1.75 MHz with auto-zero and 3.5 MHz without.
// R11 - Calibration runs on its own at power-up and no control input can interrupt it.
// R12 - The host starts a fresh calibration once supplies, reference and clock have settled.
// R13 - Calibration derives offset, linearity and gain corrections, stores them in internal memory and applies them later;
//       the code only reads the stored words out on corrOut during conversion and leaves result uncorrected.
// R14 - With auto-zero tracking drift, one calibration after power-up should suffice.
// R15 - Auto-zero is not available with sample-hold starts, which may need repeated calibration.
// R16 - In the sample-hold method the hold command is the sample-hold rising edge.
// R17 - The sequencer is a state machine idle, auto-zero, acquire, convert, done, with calibration overriding all.
package adc_seq_pkg;

    localparam int AZ_CYCLES   = 26;
    localparam int ACQ_CYCLES  = 7;
    localparam int CONV_BITS   = 13;
    localparam int CAL_CYCLES  = 1399;
    localparam int CORR_WORDS  = 16;
    localparam int CORR_W      = 8;
    localparam int CNT_W       = 11;

    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_AZ    = 6'h02,
        ST_ACQ   = 6'h04,
        ST_CONV  = 6'h08,
        ST_DONE  = 6'h10,
        ST_CAL   = 6'h20
    } seq_state_e;

    // active-low host strobes
    typedef struct packed {
        logic csN;
        logic wrN;
        logic shN;
        logic rdN;
        logic calN;
        logic autozeroEnN;
    } strobes_s;

endpackage

// ===== src/adc_acq_cal_seq.sv
// acquisition, auto-zero and calibration sequencer of the converter
`timescale 1ns/100ps
module adc_acq_cal_seq #(
    parameter int AZ_LEN   = adc_seq_pkg::AZ_CYCLES,
    parameter int ACQ_LEN  = adc_seq_pkg::ACQ_CYCLES,
    parameter int CAL_LEN  = adc_seq_pkg::CAL_CYCLES
) (
    // clock, reset, enable
    input  wire logic                   core_clk,
    input  wire logic                   sys_rst,
    input  wire logic                   clkEn,
    // host strobes, asynchronous
    input  wire adc_seq_pkg::strobes_s  strobesIn,
    // comparator decision per tested bit
    input  wire logic                   cmpIn,
    // status to host
    output logic                        eoc,
    output logic                        intN,
    output logic                        sampling,
    output logic                        calBusy,
    output logic [adc_seq_pkg::CONV_BITS-1:0] result,
    output logic [adc_seq_pkg::CORR_W-1:0]    corrOut
);
    import adc_seq_pkg::*;

    // parameter ranges the shared counter can serve
    if (AZ_LEN < 1 || ACQ_LEN < 1 || CAL_LEN < CORR_WORDS + 1
        || AZ_LEN >= (1 << CNT_W) || ACQ_LEN >= (1 << CNT_W)
        || CAL_LEN >= (1 << CNT_W)) begin : g_badParams
        $error("adc_acq_cal_seq: bad timing parameters");
    end

    // two-stage synchroniser
    strobes_s syncA_q, syncB_q, prev_q;
    logic     cmpA_q, cmpB_q;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            syncA_q <= '1;
            syncB_q <= '1;
            prev_q  <= '1;
            cmpA_q  <= 1'b0;
            cmpB_q  <= 1'b0;
        end else if (clkEn) begin
            syncA_q <= strobesIn;
            syncB_q <= syncA_q;
            prev_q  <= syncB_q;
            cmpA_q  <= cmpIn;
            cmpB_q  <= cmpA_q;
        end
    end

    // rising edge of a synchronised strobe
    function automatic logic riseOf(input logic cur, input logic old);
        return cur & ~old;
    endfunction

    logic wrRise, shRise, shFall, calRise;
    always_comb begin
        wrRise  = ~syncB_q.csN & riseOf(syncB_q.wrN, prev_q.wrN);  // R01
        shRise  = ~syncB_q.csN & riseOf(syncB_q.shN, prev_q.shN);  // R16
        shFall  = ~syncB_q.csN & riseOf(prev_q.shN, syncB_q.shN);
        calRise = riseOf(syncB_q.calN, prev_q.calN);
    end

    // sequencer state
    seq_state_e               state_q, state_d;
    logic [CNT_W-1:0]         cnt_q, cnt_d;
    logic                     eoc_q, eoc_d;
    logic                     intN_q, intN_d;
    logic                     samp_q, samp_d;
    logic                     shMode_q, shMode_d;
    logic [CONV_BITS-1:0]     sar_q, sar_d;
    logic [CONV_BITS-1:0]     res_q, res_d;
    logic [CORR_W-1:0]        corrRam [CORR_WORDS];
    logic                     corrWe;
    logic [$clog2(CORR_WORDS)-1:0] corrIdx;
    logic [CORR_W-1:0]        corrAcc_q, corrAcc_d;
    logic [CORR_W-1:0]        corrRd_q;
    logic                     calBusy_q, calBusy_d;

    always_comb begin
        state_d  = state_q;
        cnt_d    = cnt_q;
        eoc_d    = eoc_q;
        intN_d   = intN_q;
        samp_d   = samp_q;
        shMode_d = shMode_q;
        sar_d    = sar_q;
        res_d    = res_q;
        corrAcc_d = corrAcc_q;
        corrWe   = 1'b0;
        corrIdx  = cnt_q[$clog2(CORR_WORDS)-1:0];
        if (state_q == ST_CAL) begin                      // R11
            // no control input is looked at while calibrating
            cnt_d     = cnt_q + 1'b1;
            corrAcc_d = {corrAcc_q[CORR_W-2:0], cmpB_q};
            if (cnt_q < CNT_W'(CORR_WORDS))
                corrWe = 1'b1;                            // R13
            if (cnt_q == CNT_W'(CAL_LEN - 1)) begin
                state_d = ST_IDLE;
                eoc_d   = 1'b1;
            end
        end else if (calRise) begin                       // R17
            state_d = ST_CAL;
            cnt_d   = '0;
            samp_d  = 1'b0;
            intN_d  = 1'b1;
        end else if (wrRise) begin
            cnt_d    = '0;
            intN_d   = 1'b1;
            shMode_d = 1'b0;
            if (~syncB_q.autozeroEnN) begin
                state_d = ST_AZ;                          // R07
                samp_d  = 1'b0;
            end else begin
                state_d = ST_CONV;                        // R05
                samp_d  = 1'b0;
                eoc_d   = 1'b0;
                sar_d   = '0;
            end
        end else if (shFall && state_q != ST_CONV) begin
            state_d  = ST_ACQ;                            // R15
            shMode_d = 1'b1;
            samp_d   = 1'b1;
            intN_d   = 1'b1;
        end else begin
            case (state_q)
                ST_IDLE: begin
                end
                ST_AZ: begin
                    cnt_d = cnt_q + 1'b1;
                    if (cnt_q == CNT_W'(AZ_LEN - 1)) begin   // R02
                        state_d = ST_ACQ;
                        cnt_d   = '0;
                        samp_d  = 1'b1;
                    end
                end
                ST_ACQ: begin
                    cnt_d = cnt_q + 1'b1;
                    if ((shMode_q && shRise) || (!shMode_q
                        && cnt_q == CNT_W'(ACQ_LEN - 1))) begin // R08 R16
                        state_d = ST_CONV;
                        cnt_d   = '0;
                        samp_d  = 1'b0;
                        eoc_d   = 1'b0;                   // R03
                        sar_d   = '0;
                    end
                end
                ST_CONV: begin
                    cnt_d = cnt_q + 1'b1;
                    // sign decision first, one bit a clock
                    sar_d[CONV_BITS-1-cnt_q] = cmpB_q;
                    if (cnt_q == CNT_W'(CONV_BITS - 1)) begin
                        state_d = ST_DONE;
                        res_d   = sar_d;
                        res_d[CONV_BITS-1-cnt_q] = cmpB_q;
                    end
                end
                ST_DONE: begin
                    intN_d  = 1'b0;                       // R04
                    eoc_d   = 1'b1;
                    state_d = ST_IDLE;
                    // without auto-zero the next window opens with eoc rising
                    samp_d  = syncB_q.autozeroEnN;        // R05
                end
                default: state_d = ST_IDLE;
            endcase
        end
        // busy flag leaves a flop, in step with the state
        calBusy_d = (state_d == ST_CAL);
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q   <= ST_CAL;                          // R11
            cnt_q     <= '0;
            eoc_q     <= 1'b0;
            intN_q    <= 1'b1;
            samp_q    <= 1'b0;
            shMode_q  <= 1'b0;
            sar_q     <= '0;
            res_q     <= '0;
            corrAcc_q <= '0;
            calBusy_q <= 1'b1;                            // R11
        end else if (clkEn) begin
            state_q   <= state_d;
            cnt_q     <= cnt_d;
            eoc_q     <= eoc_d;
            intN_q    <= intN_d;
            samp_q    <= samp_d;
            shMode_q  <= shMode_d;
            sar_q     <= sar_d;
            res_q     <= res_d;
            corrAcc_q <= corrAcc_d;
            calBusy_q <= calBusy_d;
        end
    end

    // correction memory, read every conversion bit
    always_ff @(posedge core_clk) begin
        if (clkEn && corrWe)
            corrRam[corrIdx] <= corrAcc_q;                // R13
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst)
            corrRd_q <= '0;
        else if (clkEn && state_q == ST_CONV)
            corrRd_q <= corrRam[corrIdx];                 // R13
    end

    always_comb begin
        eoc      = eoc_q;
        intN     = intN_q;
        sampling = samp_q;
        calBusy  = calBusy_q;
        result   = res_q;
        corrOut  = corrRd_q;
    end

endmodule // adc_acq_cal_seq

// ===== test/adc_seq_properties.sv
// assertions on the sequencer ports
`timescale 1ns/100ps
module adc_seq_properties #(
    parameter int CAL_LEN = 20
) (
    // clock, reset
    input wire logic                  core_clk,
    input wire logic                  sys_rst,
    // strobes and status
    input wire adc_seq_pkg::strobes_s strobesIn,
    input wire logic                  eoc,
    input wire logic                  intN,
    input wire logic                  sampling,
    input wire logic                  calBusy
);
    import adc_seq_pkg::*;
    int   calCnt;
    logic idle;
    logic plainGo;
    assign idle = eoc && !calBusy;
    assign plainGo = !strobesIn.csN && strobesIn.autozeroEnN && idle;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) calCnt <= 0;
        else calCnt <= calBusy ? calCnt + 1 : 0;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    property p_calQuiet; calBusy |-> !sampling; endproperty
    a_calQuiet: assert property (p_calQuiet) else $error("cal sampling");
    property p_calLen; $fell(calBusy) |-> $past(calCnt) >= CAL_LEN - 2;
    endproperty
    a_calLen: assert property (p_calLen) else $error("cal short");
    property p_calGo; $rose(strobesIn.calN) && idle |-> ##[2:5] calBusy;
    endproperty
    a_calGo: assert property (p_calGo) else $error("cal not taken");
    property p_azWait; $rose(strobesIn.wrN) && !strobesIn.csN
        && !strobesIn.autozeroEnN && idle
        |-> ##4 !sampling[*8] ##[14:22] sampling; endproperty
    a_azWait: assert property (p_azWait) else $error("az length");
    property p_acqLen; $rose(sampling) && $stable(eoc)
        && !strobesIn.autozeroEnN |-> sampling[*7] ##1 (!sampling && !eoc);
    endproperty
    a_acqLen: assert property (p_acqLen) else $error("window");
    property p_plain; ($rose(strobesIn.wrN) || $rose(strobesIn.shN))
        && plainGo |-> ##[2:6] $fell(eoc); endproperty
    a_plain: assert property (p_plain) else $error("no start");
    property p_conv; $fell(eoc) && !calBusy |-> !eoc[*8] ##[5:9] $rose(eoc);
    endproperty
    a_conv: assert property (p_conv) else $error("conv length");
    property p_done; $rose(eoc) && !$past(calBusy) && !$past(calBusy, 2)
        |-> !intN; endproperty
    a_done: assert property (p_done) else $error("no int");
    c_az: cover property ($rose(sampling) && !strobesIn.autozeroEnN);
    c_done: cover property ($rose(eoc) && !intN);
    c_cal: cover property ($fell(calBusy));
endmodule // adc_seq_properties

// ===== test/adc_host_model.sv
// host model driving the converter strobes
`timescale 1ns/100ps
module adc_host_model (
    // clock and status
    input  wire logic             core_clk,
    input  wire logic             eoc,
    input  wire logic             calBusy,
    // active-low strobes
    output adc_seq_pkg::strobes_s strobes
);
    import adc_seq_pkg::*;
    // waits that ran out of time
    int stalls = 0;
    initial strobes = 6'h3F;
    task automatic waitIdle();
        int k;
        for (k = 0; k < 200 && !(eoc === 1'b1 && calBusy === 1'b0); k++)
            @(negedge core_clk);
        if (k == 200)
            stalls++;
    endtask
    task automatic calibrate();
        int k;
        @(negedge core_clk);
        strobes.calN = 1'b0;
        repeat (2) @(negedge core_clk);
        strobes.calN = 1'b1;
        for (k = 0; k < 9 && calBusy !== 1'b1; k++)
            @(negedge core_clk);
        if (k == 9)
            stalls++;
        waitIdle();
    endtask
    task automatic convert(input logic az, input logic sh, input int acq);
        int k;
        @(negedge core_clk);
        strobes.csN = 1'b0;
        strobes.autozeroEnN = ~az;
        strobes.shN = ~sh;
        strobes.wrN = sh;
        repeat (acq) @(negedge core_clk);
        strobes.shN = 1'b1;
        strobes.wrN = 1'b1;
        @(negedge core_clk);
        strobes.csN = 1'b1;
        for (k = 0; k < 60 && eoc !== 1'b0; k++)
            @(negedge core_clk);
        if (k == 60)
            stalls++;
        waitIdle();
        repeat (2) begin
            strobes.csN = 1'b0;
            strobes.rdN = 1'b0;
            @(negedge core_clk);
            strobes.rdN = 1'b1;
            strobes.csN = 1'b1;
            @(negedge core_clk);
        end
        strobes.autozeroEnN = 1'b1;
        repeat (acq) @(negedge core_clk);
    endtask
endmodule // adc_host_model

// ===== test/tb_top.sv
// self-checking bench of the converter sequencer
`timescale 1ns/100ps
module tb_top;
    import adc_seq_pkg::*;
    localparam int CAL_LEN = 20;
    logic                 core_clk = 1'b0;
    logic                 sys_rst = 1'b1;
    logic                 clkEn = 1'b1;
    logic                 cmpIn = 1'b1;  // ones through calibration
    strobes_s             strobesIn;
    logic                 eoc, intN, sampling, calBusy;
    logic [CONV_BITS-1:0] result;
    logic [CORR_W-1:0]    corrOut;
    int                   nCyc;
    logic [CONV_BITS-1:0] expQ[$];
    logic [31:0]          seed = 32'h0000000F;
    int                   n_mismatch = 0;
    int                   samples_checked = 0;
    adc_acq_cal_seq #(.CAL_LEN(CAL_LEN)) dut_u (
        .core_clk(core_clk), .sys_rst(sys_rst), .clkEn(clkEn),
        .strobesIn(strobesIn), .cmpIn(cmpIn), .eoc(eoc), .intN(intN),
        .sampling(sampling), .calBusy(calBusy), .result(result),
        .corrOut(corrOut));
    adc_host_model host_u (.core_clk(core_clk), .eoc(eoc),
        .calBusy(calBusy), .strobes(strobesIn));
    // scaled clock, one rate for every start method
    initial forever #5 core_clk = ~core_clk;
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string nm, input logic [12:0] e, g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic test_done();
        if (n_mismatch == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // mode 0 auto-zero, 1 plain start, 2 sample-hold start
    task automatic run(input int mode);
        logic [31:0] r;
        r = xs();
        cmpIn = r[0];
        expQ.push_back({CONV_BITS{r[0]}});
        host_u.convert(mode == 0, mode == 2, 3 + int'(r[3:1]));
        chk("result", expQ.pop_front(), result);
        chk("eoc", 13'h0001, 13'(eoc));
        chk("intN", 13'h0000, 13'(intN));
        chk("sampling", 13'(mode != 0), 13'(sampling));
        chk("corrOut", 13'((1 << CORR_W) - 1), 13'(corrOut));
        chk("stalls", 13'h0000, 13'(host_u.stalls));
    endtask
    initial begin
        repeat (20) @(posedge core_clk);
        @(negedge core_clk);
        sys_rst = 1'b0;
        chk("calBusy", 13'h0001, 13'(calBusy));
        chk("eoc", 13'h0000, 13'(eoc));
        // freeze ten cycles of the power-up calibration
        repeat (5) @(negedge core_clk);
        clkEn = 1'b0;
        repeat (10) @(negedge core_clk);
        clkEn = 1'b1;
        nCyc = 15;
        while (calBusy === 1'b1 && nCyc < 200) begin
            @(negedge core_clk);
            nCyc++;
        end
        chk("calCycles", 13'(CAL_LEN + 10), 13'(nCyc));
        host_u.waitIdle();
        chk("calBusy", 13'h0000, 13'(calBusy));
        host_u.calibrate();
        chk("calBusy", 13'h0000, 13'(calBusy));
        for (int i = 0; i < 12; i++) run(i % 3);
        test_done();
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        test_done();
    end
endmodule // tb_top
bind adc_acq_cal_seq adc_seq_properties #(.CAL_LEN(CAL_LEN)) chk_u (
    .core_clk(core_clk), .sys_rst(sys_rst), .strobesIn(strobesIn),
    .eoc(eoc), .intN(intN), .sampling(sampling), .calBusy(calBusy));
